// *** ccs_pkg.sv ***
// shared constants, types and register layout of the charge cycle sequencer
package ccs_pkg;

   // ****************************************
   // clock and timing
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 10;          // 100 MHz reference clock
   localparam int unsigned STAT_PULSE_NS = 128000;      // status and interrupt pulse, 128 us
   localparam int unsigned OVP_DGL_NS = 1000000;        // overvoltage deglitch, plain default
   localparam int unsigned SINK_DUR_NS = 2000000;       // sink_duration, plain default
   localparam int unsigned SOURCE_DUR_NS = 2000000;     // source_duration, plain default
   // longest times round down, never below one cycle
   localparam int unsigned STAT_PULSE_CYC = (STAT_PULSE_NS / CLK_PERIOD_NS > 0) ? STAT_PULSE_NS / CLK_PERIOD_NS : 1;
   // least times round up
   localparam int unsigned OVP_DGL_CYC = (OVP_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SINK_DUR_CYC = (SINK_DUR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SOURCE_DUR_CYC = (SOURCE_DUR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_STATE = 4'h8;
   // control register fields
   localparam int unsigned CTRL_CHG_DIS = 0;
   localparam int unsigned CTRL_TERM_EN = 1;
   localparam int unsigned CTRL_LOW_CHARGE_SELECT = 2;
   localparam int unsigned CTRL_HIZ = 3;
   localparam int unsigned CTRL_RESET = 7;
   localparam logic CHG_DIS_RST = 1'h1;                 // variant default, host must enable
   localparam logic TERM_EN_RST = 1'h1;
   localparam logic LOW_CHARGE_SELECT_RST = 1'h0;
   localparam logic HIZ_RST = 1'h0;
   // status codes in bits 1:0, fault codes in bits 3:2
   localparam logic [1:0] STAT_READY = 2'h0;
   localparam logic [1:0] STAT_CHARGING = 2'h1;
   localparam logic [1:0] STAT_DONE = 2'h2;
   localparam logic [1:0] STAT_FAULT = 2'h3;
   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] FAULT_NO_BATT = 2'h1;
   localparam logic [1:0] FAULT_BATT_OVP = 2'h2;
   localparam logic [5:0] LOOPS_ALL = 6'h3f;            // cc, cv, thermal, minimum_rail_loop, input limit, vin dpm

   typedef enum logic [2:0] {
      CCS_OFF, CCS_HIZ, CCS_SHORT_PRE, CCS_CC, CCS_CV, CCS_DET_SINK, CCS_DET_SRC, CCS_DONE
   } ccs_state_t;

   // comparator outputs from the analog side, all asynchronous
   typedef struct packed {
      logic valid_input;
      logic chip_disable_pin;
      logic vbat_above_short;
      logic sys_above_low;
      logic vbat_at_reg;
      logic ibat_below_term;
      logic ibat_below_350;
      logic vbat_above_rch;
      logic vbat_above_sink;
      logic vbat_above_src1;
      logic vbat_below_src2;
      logic vbat_above_ovp;
      logic vbat_below_ovp_hyst;
      logic other_loop;
      logic ts_warm_cool;
      logic rail_at_minimum_rail_loop;
      logic ichg_zero;
   } ccs_sense_t;

   // controls to the power stage
   typedef struct packed {
      logic converter_on;
      logic bat_switch_on;
      logic bat_switch_4x;
      logic rail_high;
      logic precharge_on;
      logic sink_on;
      logic external_discharge_gate;
      logic reduce_chg;
      logic [5:0] loops_en;
      logic params_reset;
   } ccs_drive_t;

endpackage

// *** ccs_sync.sv ***
// two flip-flop synchroniser for the comparator inputs
`timescale 1ns/1ps
`default_nettype none
module ccs_sync (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire ccs_pkg::ccs_sense_t raw,
   output ccs_pkg::ccs_sense_t synced
);
   localparam int unsigned W = $bits(ccs_pkg::ccs_sense_t);
   logic [W-1:0] meta;
   logic [W-1:0] stable;

   // ****************************************
   // per bit synchroniser
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // first stage feeds only the second stage
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               meta[i] <= 1'b0;
               stable[i] <= 1'b0;
            end else begin
               meta[i] <= raw[i];
               stable[i] <= meta[i];
            end
         end
      end
   endgenerate

   assign synced = stable;
endmodule // ccs_sync
`default_nettype wire

// *** ccs_sequencer.sv ***
// charge cycle sequencer: charge phases, termination, battery detection and battery overvoltage
// Function
// - charge disabled with input valid: battery switch off, rail high; writing 0 starts charging
// - charge-disable reset value is a per-variant parameter
// - all six current loops enabled while charging
// - shorted battery: precharge current, switch off, rail low, then programmed current
// - thermal loop stays enabled while charging to hold junction temperature
// - rail at minimum: reduce charge current; at zero current enter supplement
// - switch fully on above rail low level; constant current then constant voltage
// - switch resistance raised four times below about 350 mA
// - termination enabled: end charge at taper threshold, start detection, rail high
// - termination disabled: never terminate, keep regulating voltage
// - termination blocked by other loops, warm or cool, or low charge select
// - new cycle on recharge drop, input power-on, enable toggle, reset, chip-disable toggle
// - sink phase for sink duration; battery held above threshold means charge done
// - battery dropped: flag absent fault, reset charge parameters, keep detecting
// - source phase with hysteretic current for source duration, then sink again
// - detect until disabled, high impedance or found; found clears fault, new cycle
// - no battery detection while termination disabled
// - overvoltage stops converter and turns switch on until below hysteresis
// - overvoltage after deglitch: gate on, one status pulse, status and fault set
// - status clears when fault ends; fault clears on read after it ends
`timescale 1ns/1ps
`default_nettype none
module ccs_sequencer #(
   parameter int unsigned PULSE_CYC = ccs_pkg::STAT_PULSE_CYC,
   parameter int unsigned DGL_CYC = ccs_pkg::OVP_DGL_CYC,
   parameter int unsigned SINK_CYC = ccs_pkg::SINK_DUR_CYC,
   parameter int unsigned SRC_CYC = ccs_pkg::SOURCE_DUR_CYC,
   parameter logic CHG_DIS_DEFAULT = ccs_pkg::CHG_DIS_RST
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_we,
   input wire logic bus_re,
   output logic [7:0] bus_rdata,
   input wire ccs_pkg::ccs_sense_t sense_raw,
   output ccs_pkg::ccs_drive_t drive,
   output logic stat_pulse,
   output logic int_pulse
);

   // ****************************************
   // declarations
   // ****************************************
   ccs_pkg::ccs_sense_t s;
   ccs_pkg::ccs_state_t state;
   logic charge_disable;
   logic termination_enable_bit;
   logic low_charge_select;
   logic hiz_mode;
   logic batt_absent;
   logic ovp_active;
   logic ovp_fault;
   logic src_on;
   logic [31:0] det_cnt;
   logic [31:0] dgl_cnt;
   logic [31:0] pulse_cnt;
   logic wr_ctrl;
   logic rd_status;
   logic reset_write;
   logic enable_write;
   logic hiz_cond;
   logic charging;
   logic term_ok;
   logic sink_end;
   logic src_end;
   logic sink_fail;
   logic ovp_set;
   logic ovp_stop;
   logic supplement;
   logic [1:0] status_code_bits;
   logic [1:0] fault_code;
   ccs_pkg::ccs_state_t start_state;

   ccs_sync u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .raw(sense_raw),
      .synced(s)
   );

   // ****************************************
   // register bus decode
   // ****************************************
   assign wr_ctrl = bus_we && (bus_addr == ccs_pkg::REG_CTRL);
   assign rd_status = bus_re && (bus_addr == ccs_pkg::REG_STATUS);
   assign reset_write = wr_ctrl && bus_wdata[ccs_pkg::CTRL_RESET];
   // a 1 to 0 move of charge disable restarts charging
   assign enable_write = wr_ctrl && !reset_write && charge_disable && !bus_wdata[ccs_pkg::CTRL_CHG_DIS];

   // control register; the reset bit self-clears and restores defaults
   always_ff @(posedge ref_clk) begin
      if (!rst_n || reset_write) begin
         charge_disable <= CHG_DIS_DEFAULT;
         termination_enable_bit <= ccs_pkg::TERM_EN_RST;
         low_charge_select <= ccs_pkg::LOW_CHARGE_SELECT_RST;
         hiz_mode <= ccs_pkg::HIZ_RST;
      end else if (wr_ctrl) begin
         charge_disable <= bus_wdata[ccs_pkg::CTRL_CHG_DIS];
         termination_enable_bit <= bus_wdata[ccs_pkg::CTRL_TERM_EN];
         low_charge_select <= bus_wdata[ccs_pkg::CTRL_LOW_CHARGE_SELECT];
         hiz_mode <= bus_wdata[ccs_pkg::CTRL_HIZ];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !bus_re) begin
         bus_rdata <= 8'h00;
      end else begin
         unique case (bus_addr)
            ccs_pkg::REG_CTRL: bus_rdata <= {4'h0, hiz_mode, low_charge_select, termination_enable_bit,
                                             charge_disable};
            ccs_pkg::REG_STATUS: bus_rdata <= {4'h0, fault_code, status_code_bits};
            ccs_pkg::REG_STATE: bus_rdata <= {5'h00, state};
            default: bus_rdata <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // charge sequencing
   // ****************************************
   assign hiz_cond = !s.valid_input || s.chip_disable_pin || hiz_mode;
   assign charging = (state == ccs_pkg::CCS_SHORT_PRE) || (state == ccs_pkg::CCS_CC) ||
                     (state == ccs_pkg::CCS_CV);
   assign start_state = s.vbat_above_short ? ccs_pkg::CCS_CC : ccs_pkg::CCS_SHORT_PRE;
   // termination needs cv, taper, charged battery and no blocking condition
   assign term_ok = termination_enable_bit && s.ibat_below_term && s.vbat_above_rch &&
                    !s.other_loop && !s.ts_warm_cool && !low_charge_select;
   assign sink_end = det_cnt == SINK_CYC - 1;
   assign src_end = det_cnt == SRC_CYC - 1;
   assign sink_fail = (state == ccs_pkg::CCS_DET_SINK) && termination_enable_bit && !s.vbat_above_sink;

   // state: high impedance and disable win over every phase
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= ccs_pkg::CCS_OFF;
      end else if (hiz_cond) begin
         state <= ccs_pkg::CCS_HIZ;
      end else if (charge_disable && !enable_write) begin
         // the enabling write still sees the old disable bit, so it must not park the state
         state <= ccs_pkg::CCS_OFF;
      end else if (enable_write || reset_write) begin
         state <= start_state;
      end else begin
         unique case (state)
            // leaving off or high impedance covers power-on, enable and chip-disable toggles
            ccs_pkg::CCS_OFF, ccs_pkg::CCS_HIZ: begin
               state <= start_state;
            end
            ccs_pkg::CCS_SHORT_PRE: begin
               if (s.vbat_above_short) state <= ccs_pkg::CCS_CC;
            end
            ccs_pkg::CCS_CC: begin
               if (s.vbat_at_reg) state <= ccs_pkg::CCS_CV;
            end
            ccs_pkg::CCS_CV: begin
               if (term_ok) state <= ccs_pkg::CCS_DET_SINK;
            end
            ccs_pkg::CCS_DET_SINK: begin
               if (!termination_enable_bit) begin
                  state <= start_state;
               end else if (!s.vbat_above_sink) begin
                  state <= ccs_pkg::CCS_DET_SRC;
               end else if (sink_end) begin
                  // a battery found after an absent fault restarts charging
                  state <= batt_absent ? start_state : ccs_pkg::CCS_DONE;
               end
            end
            ccs_pkg::CCS_DET_SRC: begin
               if (!termination_enable_bit) begin
                  state <= start_state;
               end else if (src_end) begin
                  state <= ccs_pkg::CCS_DET_SINK;
               end
            end
            ccs_pkg::CCS_DONE: begin
               if (!s.vbat_above_rch) state <= start_state;
            end
         endcase
      end
   end

   // phase timer, restarted whenever a detection phase ends
   always_ff @(posedge ref_clk) begin
      if (!rst_n || hiz_cond || charge_disable) begin
         det_cnt <= 32'h0;
      end else if ((state == ccs_pkg::CCS_DET_SINK) && s.vbat_above_sink && !sink_end) begin
         det_cnt <= det_cnt + 32'h1;
      end else if ((state == ccs_pkg::CCS_DET_SRC) && !src_end) begin
         det_cnt <= det_cnt + 32'h1;
      end else begin
         det_cnt <= 32'h0;
      end
   end

   // source current hysteresis between the two source thresholds
   always_ff @(posedge ref_clk) begin
      if (!rst_n || (state != ccs_pkg::CCS_DET_SRC)) begin
         src_on <= 1'b1;
      end else if (s.vbat_above_src1) begin
         src_on <= 1'b0;
      end else if (s.vbat_below_src2) begin
         src_on <= 1'b1;
      end
   end

   // absent flag: a sink failure sets, a completed sink clears
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         batt_absent <= 1'b0;
      end else if (sink_fail) begin
         batt_absent <= 1'b1;
      end else if ((state == ccs_pkg::CCS_DET_SINK) && sink_end && s.vbat_above_sink) begin
         batt_absent <= 1'b0;
      end
   end

   // ****************************************
   // battery overvoltage
   // ****************************************
   assign ovp_set = s.vbat_above_ovp && !ovp_active && (dgl_cnt == DGL_CYC - 1);
   assign ovp_stop = s.vbat_above_ovp || ovp_active;

   // deglitch restarts on every dropout so a short glitch never reports
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !s.vbat_above_ovp || ovp_active) begin
         dgl_cnt <= 32'h0;
      end else begin
         dgl_cnt <= dgl_cnt + 32'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ovp_active <= 1'b0;
      end else if (ovp_set) begin
         ovp_active <= 1'b1;
      end else if (s.vbat_below_ovp_hyst) begin
         ovp_active <= 1'b0;
      end
   end

   // fault survives until read after the condition ends; a new set beats the read
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ovp_fault <= 1'b0;
      end else if (ovp_set) begin
         ovp_fault <= 1'b1;
      end else if (rd_status && !ovp_active) begin
         ovp_fault <= 1'b0;
      end
   end

   // status follows the live condition, fault the latched one
   assign status_code_bits = ovp_active ? ccs_pkg::STAT_FAULT :
                             batt_absent ? ccs_pkg::STAT_FAULT :
                             charging ? ccs_pkg::STAT_CHARGING :
                             (state == ccs_pkg::CCS_DONE) ? ccs_pkg::STAT_DONE : ccs_pkg::STAT_READY;
   assign fault_code = ovp_fault ? ccs_pkg::FAULT_BATT_OVP :
                       batt_absent ? ccs_pkg::FAULT_NO_BATT : ccs_pkg::FAULT_NONE;

   // single pulse, PULSE_CYC cycles wide, on both outputs
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pulse_cnt <= 32'h0;
         stat_pulse <= 1'b0;
         int_pulse <= 1'b0;
      end else if (ovp_set) begin
         pulse_cnt <= PULSE_CYC - 1;
         stat_pulse <= 1'b1;
         int_pulse <= 1'b1;
      end else begin
         pulse_cnt <= (pulse_cnt != 32'h0) ? pulse_cnt - 32'h1 : 32'h0;
         stat_pulse <= pulse_cnt != 32'h0;
         int_pulse <= pulse_cnt != 32'h0;
      end
   end

   // ****************************************
   // power stage controls
   // ****************************************
   // supplement whenever the rail sags and no charge current is left
   assign supplement = s.rail_at_minimum_rail_loop && s.ichg_zero;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         drive <= '0;
      end else begin
         drive.converter_on <= !hiz_cond && !ovp_stop;
         drive.bat_switch_on <= ovp_stop || (state == ccs_pkg::CCS_HIZ) || supplement ||
                                ((state == ccs_pkg::CCS_CC) && s.sys_above_low) ||
                                (state == ccs_pkg::CCS_CV);
         drive.bat_switch_4x <= ((state == ccs_pkg::CCS_CC) || (state == ccs_pkg::CCS_CV)) &&
                                s.ibat_below_350;
         drive.rail_high <= (state == ccs_pkg::CCS_OFF) || (state == ccs_pkg::CCS_DONE) ||
                            (state == ccs_pkg::CCS_DET_SINK) || (state == ccs_pkg::CCS_DET_SRC);
         drive.precharge_on <= (state == ccs_pkg::CCS_SHORT_PRE) ||
                               ((state == ccs_pkg::CCS_DET_SRC) && src_on);
         drive.sink_on <= state == ccs_pkg::CCS_DET_SINK;
         drive.external_discharge_gate <= (state == ccs_pkg::CCS_HIZ) || ovp_active;
         drive.reduce_chg <= charging && s.rail_at_minimum_rail_loop;
         // while charging every loop stays armed, the analog side lets the dominant one win
         drive.loops_en <= charging ? ccs_pkg::LOOPS_ALL : 6'h00;
         drive.params_reset <= sink_fail || reset_write;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence enable_req_s;
      enable_write && !hiz_cond;
   endsequence
   sequence cycle_begins_s;
      (state == ccs_pkg::CCS_SHORT_PRE) || (state == ccs_pkg::CCS_CC);
   endsequence

   disabled_hold_a: assert property ((state == ccs_pkg::CCS_OFF) |=>
      (drive.rail_high && !drive.bat_switch_on)) else $error("disabled state not holding rail high");
   enable_start_a: assert property (enable_req_s ##1 !hiz_cond |-> cycle_begins_s)
      else $error("enable write did not start a charge cycle");
   loops_on_a: assert property (charging |=> drive.loops_en == 6'h3f)
      else $error("current loops not all enabled while charging");
   short_pre_a: assert property ((state == ccs_pkg::CCS_SHORT_PRE) && !ovp_stop |=>
      (drive.precharge_on && !drive.bat_switch_on && !drive.rail_high)) else $error("precharge drive wrong");
   term_block_a: assert property ((state == ccs_pkg::CCS_CV) && (s.other_loop || low_charge_select)
      |=> state != ccs_pkg::CCS_DET_SINK) else $error("termination not blocked");
   no_detect_a: assert property (!termination_enable_bit && !$past(termination_enable_bit) |->
      (state != ccs_pkg::CCS_DET_SINK) && (state != ccs_pkg::CCS_DET_SRC)) else $error("detection without term");
   sink_fail_a: assert property (sink_fail && !hiz_cond && !charge_disable && !reset_write |=>
      (batt_absent && drive.params_reset && state == ccs_pkg::CCS_DET_SRC)) else $error("sink failure mishandled");
   ovp_pulse_a: assert property ($rose(ovp_active) |-> stat_pulse && int_pulse ##1
      (stat_pulse && int_pulse && ovp_fault)) else $error("overvoltage pulse missing");
   glitch_quiet_a: assert property (!ovp_active && !s.vbat_above_ovp && (dgl_cnt != 32'h0) && !rd_status
      |=> !ovp_active && $stable(ovp_fault)) else $error("overvoltage glitch reported");
   fault_hold_a: assert property (ovp_fault && ovp_active |=> ovp_fault)
      else $error("fault cleared while overvoltage present");
   ovp_stop_a: assert property (s.vbat_above_ovp |=> !drive.converter_on && drive.bat_switch_on)
      else $error("converter not stopped on overvoltage");
   switch_4x_a: assert property ((state == ccs_pkg::CCS_CV) && s.ibat_below_350 |=> drive.bat_switch_4x)
      else $error("switch resistance not raised");

endmodule // ccs_sequencer
`default_nettype wire

// *** ccs_batt_model.sv ***
// battery and comparator model facing the charge cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module ccs_batt_model (
   input wire ccs_pkg::ccs_drive_t drive,
   input wire logic present,
   input wire logic full,
   input wire logic ovp,
   output ccs_pkg::ccs_sense_t sense
);
   // comparator levels follow the knobs at once; the dut synchroniser adds the latency
   always_comb begin
      sense = '0;
      sense.valid_input = 1'h1;
      sense.vbat_above_short = present;
      sense.sys_above_low = present;
      sense.vbat_at_reg = full;
      sense.ibat_below_term = full;
      sense.ibat_below_350 = full;
      sense.vbat_above_rch = present; // no recharge drop while present
      sense.vbat_above_sink = present; // missing cell collapses under the sink load
      sense.vbat_above_src1 = !present && drive.precharge_on;
      sense.vbat_below_src2 = !present && !drive.precharge_on;
      sense.vbat_above_ovp = ovp;
      sense.vbat_below_ovp_hyst = !ovp;
   end
endmodule // ccs_batt_model
`default_nettype wire

// *** tb_charge_cycle_sequencer.sv ***
// self-checking testbench of the charge cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_charge_cycle_sequencer;
   logic ref_clk, rst_n, bus_we, bus_re, rd_d, present, full, ovp;
   logic [3:0] bus_addr;
   logic [7:0] bus_wdata, bus_rdata;
   logic [15:0] lfsr_q;
   logic [15:0] exp_q[$];
   ccs_pkg::ccs_sense_t sense;
   ccs_pkg::ccs_drive_t drive;
   logic stat_pulse, int_pulse;
   int failures, tests_run, width;
   // ****************************************
   // clock, dut and battery
   // ****************************************
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   ccs_sequencer #(.PULSE_CYC(8), .DGL_CYC(4), .SINK_CYC(6), .SRC_CYC(6), .CHG_DIS_DEFAULT(1'h1)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we),
      .bus_re(bus_re), .bus_rdata(bus_rdata), .sense_raw(sense), .drive(drive), .stat_pulse(stat_pulse),
      .int_pulse(int_pulse));
   ccs_batt_model batt (.drive(drive), .present(present), .full(full), .ovp(ovp), .sense(sense));
   // ****************************************
   // tasks
   // ****************************************
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_we <= 1'h1;
      @(posedge ref_clk);
      bus_we <= 1'h0;
   endtask
   // the expected byte and its mask go on the queue with the request
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_re <= 1'h1;
      exp_q.push_back({exp, m});
      @(posedge ref_clk);
      bus_re <= 1'h0;
   endtask
   task automatic give_verdict;
      $display("failures %0d tests_run %0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // read data stand one cycle only, so they are compared mid-cycle after the read edge
   always @(posedge ref_clk) rd_d <= bus_re;
   always @(negedge ref_clk) begin
      logic [15:0] e;
      if (rd_d && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("bus_rdata", bus_rdata & e[7:0], e[15:8]);
      end
   end
   // measures the next status pulse, bounded so a missing pulse reads as width 0
   task automatic pulse_width;
      width = 0;
      for (int i = 0; i < 30 && stat_pulse !== 1'h1; i++) @(negedge ref_clk);
      while (stat_pulse === 1'h1 && width < 40) begin
         check("int_pulse", int_pulse, 8'h01);
         width++;
         @(negedge ref_clk);
      end
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk);
      failures++;
      give_verdict();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst_n, bus_we, bus_re, rd_d, full, ovp, bus_addr, bus_wdata} = '0;
      present = 1'h1;
      failures = 0;
      tests_run = 0;
      lfsr_q = 16'h86b2;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'h1;
      repeat (6) @(negedge ref_clk);
      check("rail_high", drive.rail_high, 8'h01);
      check("bat_switch_on", drive.bat_switch_on, 8'h00);
      rd(4'h0, 8'h03, 8'hff);
      rd(4'h8, 8'h00, 8'h07);
      // random write to an unmapped place must leave control alone
      lfsr_q = lfsr(lfsr_q);
      wr(4'hc, lfsr_q[7:0]);
      rd(4'hc, 8'h00, 8'hff);
      rd(4'h0, 8'h03, 8'hff);
      wr(4'h0, 8'h02);
      repeat (8) @(negedge ref_clk);
      check("loops_en", {2'h0, drive.loops_en}, {2'h0, ccs_pkg::LOOPS_ALL});
      check("bat_switch_on", drive.bat_switch_on, 8'h01);
      rd(4'h8, 8'h03, 8'h07);
      full <= 1'h1;
      repeat (30) @(negedge ref_clk);
      rd(4'h8, 8'h07, 8'h07);
      // short overvoltage glitch below the deglitch span
      ovp <= 1'h1;
      @(posedge ref_clk);
      ovp <= 1'h0;
      pulse_width();
      check("glitch_width", width[7:0], 8'h00);
      rd(4'h4, 8'h00, 8'h0c);
      ovp <= 1'h1;
      repeat (4) @(negedge ref_clk);
      check("converter_on", drive.converter_on, 8'h00);
      check("bat_switch_on", drive.bat_switch_on, 8'h01);
      pulse_width();
      check("pulse_width", width[7:0], 8'h08);
      check("discharge_gate", drive.external_discharge_gate, 8'h01);
      rd(4'h4, 8'h0b, 8'h0f);
      ovp <= 1'h0;
      repeat (8) @(negedge ref_clk);
      rd(4'h4, 8'h08, 8'h0c);
      rd(4'h4, 8'h00, 8'h0c);
      wr(4'h0, 8'h80);
      rd(4'h0, 8'h03, 8'hff);
      // cell pulled one cycle after the enabling write, once already in constant voltage: detection must flag it
      wr(4'h0, 8'h02);
      @(posedge ref_clk);
      present <= 1'h0;
      repeat (12) @(negedge ref_clk);
      rd(4'h4, 8'h07, 8'h0f);
      present <= 1'h1;
      repeat (40) @(negedge ref_clk);
      rd(4'h4, 8'h02, 8'h0f);
      // a collapsed cell drops below recharge and restarts in short precharge
      present <= 1'h0;
      repeat (6) @(negedge ref_clk);
      check("precharge_on", drive.precharge_on, 8'h01);
      check("rail_high", drive.rail_high, 8'h00);
      rd(4'h8, 8'h02, 8'h07);
      // high impedance bit overrides every phase
      wr(4'h0, 8'h0a);
      repeat (4) @(negedge ref_clk);
      check("converter_on", drive.converter_on, 8'h00);
      rd(4'h8, 8'h01, 8'h07);
      repeat (4) @(posedge ref_clk);
      give_verdict();
   end
endmodule // tb_charge_cycle_sequencer
`default_nettype wire
